//--- testbench/tb.sv
// self-checking bench for tmzp_timer0
// assumes the checker is bound in its own file
`timescale 1ns/1ns
module tb;
   reg i_core_clk = 1'b0, i_reset = 1'b1, i_psel = 1'b0, i_penable = 1'b0;
   reg i_pwrite = 1'b0, i_instr_tick = 1'b0, i_count_pin = 1'b0, i_sleep = 1'b0;
   reg [11:0] i_paddr = 12'h000;
   reg [31:0] i_pwdata = 32'h0, q;
   reg [3:0] i_pstrb = 4'hF;
   wire o_pready, o_pslverr, o_overflow_irq;
   wire [31:0] o_prdata;
   integer fail_count = 0, num_checks = 0, s;
   always #10 i_core_clk = ~i_core_clk;
   tmzp_timer0 tmzp_timer0_inst (.*);
   // ======
   // tasks
   task chk(input [31:0] got, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task xfer(input w, input [11:0] a, input [7:0] d);
      begin
         i_psel <= 1'b1;
         i_pwrite <= w;
         i_paddr <= a;
         i_pwdata <= {24'h0, d};
         @(posedge i_core_clk);
         i_penable <= 1'b1;
         @(posedge i_core_clk);
         while (o_pready !== 1'b1) @(posedge i_core_clk);
         q = o_prdata;
         i_penable <= 1'b0;
      end
   endtask
   task rd(input [11:0] a, input [7:0] x);
      begin
         xfer(1'b0, a, 8'h00);
         chk(q, {24'h0, x});
      end
   endtask
   task tk(input integer k, input t);
      begin
         i_psel <= 1'b0;
         repeat (k) begin
            i_instr_tick <= t;
            @(posedge i_core_clk);
            i_instr_tick <= 1'b0;
            @(posedge i_core_clk);
         end
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", num_checks, fail_count);
         if (fail_count == 0 && num_checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      #300000;
      fail_count = fail_count + 1;
      end_of_test;
   end
   // ======
   // tests
   initial begin
      repeat (20) @(posedge i_core_clk);
      i_reset <= 1'b0;
      @(posedge i_core_clk);
      rd(12'h00C, 8'hFF);
      rd(12'h008, 8'h00);
      rd(12'h004, 8'h00);
      rd(12'h014, 8'h00);
      $display("reset done");
      for (s = 0; s < 8; s = s + 1) begin
         xfer(1'b1, 12'h00C, {5'h18, s[2:0]});
         xfer(1'b1, 12'h000, 8'h00);
         tk((2 << s) - 1, 1'b1);
         rd(12'h000, 8'h00);
         xfer(1'b1, 12'h000, 8'h05);
         tk((2 << s) - 1, 1'b1);
         rd(12'h000, 8'h05);
         tk(1, 1'b1);
         rd(12'h000, 8'h06);
         rd(12'h00C, {5'h18, s[2:0]});
      end
      $display("prescale done");
      xfer(1'b1, 12'h00C, 8'h88);
      rd(12'h00C, 8'h88);
      xfer(1'b1, 12'h004, 8'hFF);
      xfer(1'b1, 12'h000, 8'hFE);
      tk(2, 1'b1);
      rd(12'h004, 8'h00);
      rd(12'h008, 8'h04);
      chk(o_overflow_irq, 1'b0);
      xfer(1'b1, 12'h008, 8'h24);
      tk(1, 1'b0);
      chk(o_overflow_irq, 1'b1);
      xfer(1'b1, 12'h008, 8'h20);
      rd(12'h008, 8'h20);
      xfer(1'b1, 12'h00C, 8'hC8);
      xfer(1'b1, 12'h004, 8'h12);
      xfer(1'b1, 12'h000, 8'hFF);
      tk(1, 1'b1);
      rd(12'h004, 8'h12);
      rd(12'h008, 8'h24);
      xfer(1'b1, 12'h00C, 8'h48);
      tk(3, 1'b1);
      rd(12'h000, 8'h00);
      xfer(1'b1, 12'h008, 8'h20);
      xfer(1'b1, 12'h00C, 8'hC8);
      xfer(1'b1, 12'h000, 8'hFF);
      i_sleep <= 1'b1;
      tk(4, 1'b0);
      tk(3, 1'b1);
      rd(12'h000, 8'hFF);
      xfer(1'b1, 12'h010, 8'h01);
      i_sleep <= 1'b0;
      tk(4, 1'b0);
      tk(3, 1'b1);
      rd(12'h010, 8'h01);
      rd(12'h000, 8'hFF);
      xfer(1'b1, 12'h010, 8'h00);
      xfer(1'b1, 12'h000, 8'h00);
      $display("sleep done");
      for (s = 0; s < 2; s = s + 1) begin
         xfer(1'b1, 12'h00C, {3'h5, s[0], 4'h8});
         i_count_pin <= 1'b1;
         tk(4, 1'b0);
         rd(12'h000, 8'h01);
         i_count_pin <= 1'b0;
         tk(4, 1'b0);
         rd(12'h000, 8'h01 + {7'h0, s[0]});
      end
      xfer(1'b1, 12'h008, 8'h04);
      rd(12'h008, 8'h04);
      chk(o_overflow_irq, 1'b0);
      $display("count done");
      end_of_test;
   end
endmodule

//--- testbench/tmzp_chk.sv
// checker for timer0 apb and overflow behaviour
// assumes a bind onto the tmzp_timer0 ports
`timescale 1ns/1ns
module tmzp_chk (
   input wire i_core_clk,
   input wire i_reset,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire [3:0] i_pstrb,
   input wire o_pready,
   input wire o_pslverr,
   input wire [31:0] o_prdata,
   input wire i_sleep,
   input wire o_overflow_irq
);
   // ======
   // properties
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   wire acc = i_psel & i_penable;
   wire wr_int = acc & i_pwrite & i_pstrb[0] & (i_paddr == 12'h008);
   sequence wr_ctl_s;
      acc && i_pwrite && i_pstrb[0] && i_paddr == 12'h00C;
   endsequence
   sequence rd_ctl_s;
      acc && !i_pwrite && i_paddr == 12'h00C;
   endsequence
   a_ready_high: assert property (o_pready) else $error("ready low");
   a_read_upper: assert property (acc && !i_pwrite |-> o_prdata[31:8] == 24'h0)
      else $error("upper bits set");
   a_unmapped_err: assert property (acc && i_paddr[11:2] > 10'h004 |-> o_pslverr)
      else $error("no slave error");
   a_mapped_ok: assert property (acc && i_paddr[11:2] <= 10'h004 |-> !o_pslverr)
      else $error("bad slave error");
   a_irq_masked: assert property (wr_int && !i_pwdata[5] |=> !o_overflow_irq)
      else $error("irq not masked");
   a_flag_held: assert property (o_overflow_irq && !wr_int |=> o_overflow_irq)
      else $error("flag dropped");
   a_sleep_quiet: assert property (i_sleep [*6] ##0 !wr_int |=> !$rose(o_overflow_irq))
      else $error("overflow in sleep");
   a_ctl_readback: assert property (wr_ctl_s ##2 rd_ctl_s |->
      o_prdata[7:0] == $past(i_pwdata[7:0], 2)) else $error("control readback");
endmodule
bind tmzp_timer0 tmzp_chk tmzp_chk_inst (.*);

//--- verilog/tmzp_defines.vh
// register offsets, field positions and reset values for the timer0 block
// assumes a 32-bit apb slave, one register per aligned word
`ifndef TMZP_DEFINES_VH
`define TMZP_DEFINES_VH
// ==========================================
// register byte offsets
`define TMZP_ADDR_COUNT_LOW 12'h000
`define TMZP_ADDR_COUNT_HIGH 12'h004
`define TMZP_ADDR_INT_CTRL 12'h008
`define TMZP_ADDR_TIMER_CTRL 12'h00C
`define TMZP_ADDR_SLEEP 12'h010
// ==========================================
// timer0_control fields
`define TMZP_CTL_RUN 7
`define TMZP_CTL_EIGHT 6
`define TMZP_CTL_SRC 5
`define TMZP_CTL_EDGE 4
`define TMZP_CTL_BYPASS 3
`define TMZP_CTL_RATIO_HI 2
`define TMZP_CTL_RATIO_LO 0
// ==========================================
// interrupt_control fields
`define TMZP_INT_OVF_EN 5
`define TMZP_INT_OVF_FLAG 2
// ==========================================
// reset values
`define TMZP_RST_CTRL 8'hFF
`define TMZP_RST_INT 8'h00
`define TMZP_RST_COUNT 8'h00
`endif

//--- verilog/tmzp_timer0.v
// timer0 with 8-bit prescaler, overflow flag and apb register access
// assumes one 50 mhz clock, apb master on the same clock, async count pin
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "tmzp_defines.vh"

// Contract
// - hidden 8-bit prescaler counter
// - bypass and ratio in control low nibble
// - bypass clear assigns ratios 1:2..1:256
// - count write clears prescaler when assigned
// - count write keeps prescaler assignment
// - assignment changeable while timer runs
// - flag on FFh or FFFFh wrap
// - enable bit 5 masks overflow request
// - timer stops during sleep
// - control bit layout run..ratio
// - enable bit 5, flag bit 2
// - count as low and high bytes
module tmzp_timer0 #(
   parameter PRESCALE_WIDTH = 8
) (
   input wire i_core_clk,
   input wire i_reset,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire [3:0] i_pstrb,
   output wire o_pready,
   output wire o_pslverr,
   output reg [31:0] o_prdata,
   input wire i_instr_tick,
   input wire i_count_pin,
   input wire i_sleep,
   output wire o_overflow_irq
);

// ==========================================
// registers
reg [7:0] timer0_control_ff;
reg [7:0] interrupt_control_ff;
reg [7:0] count_low_ff;
reg [7:0] count_high_ff;
reg [PRESCALE_WIDTH-1:0] prescale_ff;
reg [2:0] pin_sync_ff;
reg sleep_sync1_ff;
reg sleep_sync2_ff;
reg sleep_sync3_ff;
reg sleep_ff;
reg pin_level_ff;
reg sleep_level_ff;
reg irq_ff;
reg [31:0] rd_mux;

reg [7:0] nxt_timer0_control;
reg [7:0] nxt_interrupt_control;
reg [7:0] nxt_count_low;
reg [7:0] nxt_count_high;
reg [PRESCALE_WIDTH-1:0] nxt_prescale;

wire wr_access;
wire wr_low;
wire wr_high;
wire wr_ctrl;
wire wr_int;
wire wr_sleep;
wire mapped;
wire run_en;
wire eight_bit;
wire src_pin;
wire edge_fall;
wire bypass;
wire [2:0] ratio_sel;
wire pin_rise;
wire pin_fall;
wire src_event;
wire timer_tick;
wire [15:0] count_now;
wire [15:0] count_inc;
wire overflow;
wire sleeping;
wire nxt_pin_level;
wire nxt_sleep_level;

// ==========================================
// helpers
function hit;
   input [11:0] addr;
   input [11:0] offset;
   begin
      hit = (addr[11:2] == offset[11:2]);
   end
endfunction

// true when the prescaler count completes one period of the chosen ratio
function ratio_done;
   input [7:0] pre;
   input [2:0] sel;
   reg [8:0] mask;
   begin
      mask = (9'h002 << sel) - 9'h001;
      ratio_done = ((pre & mask[7:0]) == mask[7:0]);
   end
endfunction

// level moves only once the two older sync stages agree
function agree_level;
   input newer;
   input older;
   input held;
   begin
      agree_level = (newer == older) ? older : held;
   end
endfunction

// ==========================================
// apb decode
assign o_pready = 1'b1;
assign mapped = hit(i_paddr, `TMZP_ADDR_COUNT_LOW) | hit(i_paddr, `TMZP_ADDR_COUNT_HIGH)
   | hit(i_paddr, `TMZP_ADDR_INT_CTRL) | hit(i_paddr, `TMZP_ADDR_TIMER_CTRL)
   | hit(i_paddr, `TMZP_ADDR_SLEEP);
assign o_pslverr = i_psel & i_penable & ~mapped;
assign wr_access = i_psel & i_penable & i_pwrite & i_pstrb[0];
assign wr_low = wr_access & hit(i_paddr, `TMZP_ADDR_COUNT_LOW);
assign wr_high = wr_access & hit(i_paddr, `TMZP_ADDR_COUNT_HIGH);
assign wr_ctrl = wr_access & hit(i_paddr, `TMZP_ADDR_TIMER_CTRL);
assign wr_int = wr_access & hit(i_paddr, `TMZP_ADDR_INT_CTRL);
assign wr_sleep = wr_access & hit(i_paddr, `TMZP_ADDR_SLEEP);

// ==========================================
// control fields
assign run_en = timer0_control_ff[`TMZP_CTL_RUN];
assign eight_bit = timer0_control_ff[`TMZP_CTL_EIGHT];
assign src_pin = timer0_control_ff[`TMZP_CTL_SRC];
assign edge_fall = timer0_control_ff[`TMZP_CTL_EDGE];
assign bypass = timer0_control_ff[`TMZP_CTL_BYPASS];
assign ratio_sel = timer0_control_ff[`TMZP_CTL_RATIO_HI:`TMZP_CTL_RATIO_LO];
assign nxt_sleep_level = agree_level(sleep_sync2_ff, sleep_sync3_ff, sleep_level_ff);
assign sleeping = sleep_level_ff | sleep_ff;

// ==========================================
// count pin synchroniser and edge detect
assign nxt_pin_level = agree_level(pin_sync_ff[1], pin_sync_ff[2], pin_level_ff);
assign pin_rise = nxt_pin_level & ~pin_level_ff;
assign pin_fall = ~nxt_pin_level & pin_level_ff;
assign src_event = src_pin ? (edge_fall ? pin_fall : pin_rise) : i_instr_tick;

// ==========================================
// prescaler and count
assign timer_tick = run_en & ~sleeping & src_event
   & (bypass | ratio_done(prescale_ff[7:0], ratio_sel));
assign count_now = {count_high_ff, count_low_ff};
assign count_inc = eight_bit ? {count_high_ff, count_low_ff + 8'h01} : count_now + 16'h0001;
assign overflow = timer_tick
   & (eight_bit ? (count_low_ff == 8'hFF) : (count_now == 16'hFFFF));
assign o_overflow_irq = irq_ff;

// ==========================================
// prescaler next value
always @* begin
   nxt_prescale = prescale_ff;
   // advances only when assigned; a control write never touches it
   if (run_en & ~sleeping & src_event & ~bypass) begin
      nxt_prescale = prescale_ff + {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1};
   end
   if ((wr_low | wr_high) & ~bypass) begin
      nxt_prescale = {PRESCALE_WIDTH{1'b0}};
   end
end

// ==========================================
// count next value
always @* begin
   nxt_count_low = count_low_ff;
   nxt_count_high = count_high_ff;
   if (timer_tick) begin
      nxt_count_low = count_inc[7:0];
      nxt_count_high = count_inc[15:8];
   end
   if (wr_low) begin
      nxt_count_low = i_pwdata[7:0];
   end
   if (wr_high) begin
      nxt_count_high = i_pwdata[7:0];
   end
end

// ==========================================
// control next value
always @* begin
   nxt_timer0_control = timer0_control_ff;
   if (wr_ctrl) begin
      nxt_timer0_control = i_pwdata[7:0];
   end
end

// ==========================================
// interrupt control next value
always @* begin
   nxt_interrupt_control = interrupt_control_ff;
   if (wr_int) begin
      nxt_interrupt_control = i_pwdata[7:0];
   end
   // hardware set wins over a same-cycle software clear
   if (overflow) begin
      nxt_interrupt_control[`TMZP_INT_OVF_FLAG] = 1'b1;
   end
end

// ==========================================
// control and interrupt state
always @(posedge i_core_clk) begin
   if (i_reset) begin
      timer0_control_ff <= `TMZP_RST_CTRL;
      interrupt_control_ff <= `TMZP_RST_INT;
      irq_ff <= 1'b0;
   end else begin
      timer0_control_ff <= nxt_timer0_control;
      interrupt_control_ff <= nxt_interrupt_control;
      irq_ff <= nxt_interrupt_control[`TMZP_INT_OVF_FLAG]
         & nxt_interrupt_control[`TMZP_INT_OVF_EN];
   end
end

// ==========================================
// count and prescaler state
always @(posedge i_core_clk) begin
   if (i_reset) begin
      count_low_ff <= `TMZP_RST_COUNT;
      count_high_ff <= `TMZP_RST_COUNT;
      prescale_ff <= {PRESCALE_WIDTH{1'b0}};
   end else begin
      count_low_ff <= nxt_count_low;
      count_high_ff <= nxt_count_high;
      prescale_ff <= nxt_prescale;
   end
end

// ==========================================
// count pin synchroniser state
always @(posedge i_core_clk) begin
   if (i_reset) begin
      pin_sync_ff <= 3'h0;
      pin_level_ff <= 1'b0;
   end else begin
      pin_sync_ff <= {pin_sync_ff[1:0], i_count_pin};
      pin_level_ff <= nxt_pin_level;
   end
end

// ==========================================
// sleep pin synchroniser state
always @(posedge i_core_clk) begin
   if (i_reset) begin
      sleep_sync1_ff <= 1'b0;
      sleep_sync2_ff <= 1'b0;
      sleep_sync3_ff <= 1'b0;
      sleep_level_ff <= 1'b0;
   end else begin
      sleep_sync1_ff <= i_sleep;
      sleep_sync2_ff <= sleep_sync1_ff;
      sleep_sync3_ff <= sleep_sync2_ff;
      sleep_level_ff <= nxt_sleep_level;
   end
end

// ==========================================
// software sleep bit
always @(posedge i_core_clk) begin
   if (i_reset) begin
      sleep_ff <= 1'b0;
   end else if (wr_sleep) begin
      sleep_ff <= i_pwdata[0];
   end
end

// ==========================================
// read mux
always @* begin
   rd_mux = 32'h00000000;
   if (hit(i_paddr, `TMZP_ADDR_COUNT_LOW)) begin
      rd_mux[7:0] = count_low_ff;
   end else if (hit(i_paddr, `TMZP_ADDR_COUNT_HIGH)) begin
      rd_mux[7:0] = count_high_ff;
   end else if (hit(i_paddr, `TMZP_ADDR_INT_CTRL)) begin
      rd_mux[7:0] = interrupt_control_ff;
   end else if (hit(i_paddr, `TMZP_ADDR_TIMER_CTRL)) begin
      rd_mux[7:0] = timer0_control_ff;
   end else if (hit(i_paddr, `TMZP_ADDR_SLEEP)) begin
      rd_mux[0] = sleep_ff;
   end
end

// ==========================================
// read data register, loaded in the setup cycle
always @(posedge i_core_clk) begin
   if (i_reset) begin
      o_prdata <= 32'h00000000;
   end else if (i_psel & ~i_penable) begin
      o_prdata <= rd_mux;
   end
end

endmodule
